// file: hdl/stream_write_feature_decode.sv
// stream write command decoder with completion time limit enforcement
// assumes the link layer delivers command writes, sector and error events
// as single-cycle strobes synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module stream_write_feature_decode #(
    parameter int MIN_LIMIT = 32'h0000_03e8 // device minimum limit in us
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // command block write from the host
    input wire logic i_cmd_wr,
    input wire stream_write_pkg::cmd_block_t i_cmd,
    // identify words 99:98, microseconds per limit unit
    input wire logic [31:0] i_limit_unit,
    // stream configuration: stored default limit per stream
    input wire logic i_cfg_wr,
    input wire logic [2:0] i_cfg_stream,
    input wire logic [31:0] i_cfg_limit,
    // data path events
    input wire logic i_sector_done,
    input wire logic i_xfer_err,
    input wire stream_write_pkg::xfer_err_t i_xfer_err_kind,
    input wire logic i_flush_done,
    // outputs toward data path and host
    output logic o_xfer_req,
    output logic o_flush_req,
    output stream_write_pkg::feature_t o_feature,
    output logic [31:0] o_stream_default,
    output logic [16:0] o_sectors_left,
    output stream_write_pkg::status_t o_status,
    output stream_write_pkg::err_log_t o_err_log,
    output logic o_done
);
    // *****************************************
    // state
    // *****************************************
    typedef struct packed {
        stream_write_pkg::phase_t phase;
        stream_write_pkg::feature_t feat;
        logic [16:0] left;         // sectors still to move
        logic limit_on;            // a limit applies
        logic [39:0] limit_us;     // microseconds remaining
        logic [7:0] presc;         // core cycles within a microsecond
        logic had_err;             // an error was seen this command
        logic timed_out;
        stream_write_pkg::status_t status;
        stream_write_pkg::err_log_t elog;
        logic done;
        logic [7:0] cfg_valid;     // stream has been configured
        logic [7:0][31:0] def_limit;
    } state_t;

    state_t cur;
    state_t next_cur;

    // decode feature byte of the incoming command; o_feature shows the stored result
    function automatic stream_write_pkg::feature_t decode_feature(input logic [7:0] f);
        stream_write_pkg::feature_t d;
        d.urgent_request = f[stream_write_pkg::URGENT_BIT];
        d.continuous_write = f[stream_write_pkg::CONTINUOUS_BIT];
        d.flush = f[stream_write_pkg::FLUSH_BIT];
        d.resume_after_error = f[stream_write_pkg::RESUME_BIT];
        d.stream_selector = f[stream_write_pkg::SELECTOR_LSB +: stream_write_pkg::SELECTOR_W];
        return d;
    endfunction

    // *****************************************
    // limit computation at command write
    // *****************************************
    stream_write_pkg::feature_t new_feat;
    logic [39:0] asked_us;
    logic [39:0] chosen_us;
    logic chosen_on;
    logic [31:0] sel_default;
    logic sel_valid;

    // pick the limit for the incoming command
    always_comb begin
        new_feat = decode_feature(i_cmd.feature_current_byte);
        sel_default = cur.def_limit[new_feat.stream_selector];
        sel_valid = cur.cfg_valid[new_feat.stream_selector];
        asked_us = 40'(i_cmd.feature_previous_byte) * 40'(i_limit_unit);
        if (i_cmd.feature_previous_byte != 8'h00) begin
            chosen_on = 1'b1;
            chosen_us = asked_us;
        end else if (sel_valid && sel_default != 32'h0000_0000) begin
            chosen_on = 1'b1;
            chosen_us = 40'(sel_default);
        end else begin
            chosen_on = 1'b0;
            chosen_us = 40'h00_0000_0000;
        end
        // raise short limits to the device floor
        if (chosen_on && chosen_us < 40'(MIN_LIMIT)) begin
            chosen_us = 40'(MIN_LIMIT);
        end
    end

    // *****************************************
    // next state
    // *****************************************
    logic us_tick;
    logic expired;
    logic last_sector;

    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        us_tick = (cur.presc == 8'(stream_write_pkg::CYCLES_PER_US - 1));
        expired = cur.limit_on && cur.limit_us == 40'h00_0000_0000;
        last_sector = i_sector_done && cur.left == 17'h0_0001;

        // stream configuration may arrive at any time
        if (i_cfg_wr) begin
            next_cur.def_limit[i_cfg_stream] = i_cfg_limit;
            next_cur.cfg_valid[i_cfg_stream] = 1'b1;
        end

        // microsecond timer, runs only while a command is open
        if (cur.phase != stream_write_pkg::ST_IDLE && cur.phase != stream_write_pkg::ST_FINISH) begin
            next_cur.presc = us_tick ? 8'h00 : cur.presc + 8'h01;
            if (us_tick && cur.limit_on && !expired) begin
                next_cur.limit_us = cur.limit_us - 40'h00_0000_0001;
            end
        end

        case (cur.phase)
            stream_write_pkg::ST_IDLE: begin
                // only the stream write command is taken, and not while busy
                if (i_cmd_wr && i_cmd.opcode == stream_write_pkg::OPC_WRITE_STREAM_DMA) begin
                    next_cur.phase = stream_write_pkg::ST_XFER;
                    next_cur.feat = new_feat;
                    next_cur.left = {i_cmd.sector_count_high_byte, i_cmd.sector_count_low_byte}
                        == 16'h0000 ? stream_write_pkg::FULL_COUNT
                        : {1'b0, i_cmd.sector_count_high_byte, i_cmd.sector_count_low_byte};
                    next_cur.limit_on = chosen_on;
                    next_cur.limit_us = chosen_us;
                    next_cur.presc = 8'h00;
                    next_cur.had_err = 1'b0;
                    next_cur.timed_out = 1'b0;
                    next_cur.elog = '0;
                    next_cur.status.busy = 1'b1;
                    next_cur.status.stream_error = 1'b0;
                    next_cur.status.error = 1'b0;
                end
            end
            stream_write_pkg::ST_XFER: begin
                if (i_sector_done) begin
                    next_cur.left = cur.left - 17'h0_0001;
                end
                // log error types; the log keeps every kind seen
                if (i_xfer_err) begin
                    next_cur.had_err = 1'b1;
                    next_cur.elog.interface_crc_error =
                        cur.elog.interface_crc_error | i_xfer_err_kind.interface_crc_error;
                    next_cur.elog.id_not_found_error =
                        cur.elog.id_not_found_error | i_xfer_err_kind.id_not_found_error;
                    next_cur.elog.aborted_command_error =
                        cur.elog.aborted_command_error | i_xfer_err_kind.aborted_command_error;
                end
                if (expired) begin
                    next_cur.timed_out = 1'b1;
                    next_cur.elog.completion_timeout_flag = 1'b1;
                    next_cur.phase = stream_write_pkg::ST_FINISH;
                end else if (i_xfer_err && !cur.feat.continuous_write) begin
                    // without continuous write an error ends the command
                    next_cur.phase = stream_write_pkg::ST_FINISH;
                end else if (last_sector) begin
                    // continuous write rides over errors to the last sector
                    next_cur.phase = cur.feat.flush ? stream_write_pkg::ST_FLUSH
                        : stream_write_pkg::ST_FINISH;
                end
            end
            stream_write_pkg::ST_FLUSH: begin
                // completion waits until the stream is on the media or the limit expires
                if (expired) begin
                    next_cur.timed_out = 1'b1;
                    next_cur.elog.completion_timeout_flag = 1'b1;
                    next_cur.phase = stream_write_pkg::ST_FINISH;
                end else if (i_flush_done) begin
                    next_cur.phase = stream_write_pkg::ST_FINISH;
                end
            end
            stream_write_pkg::ST_FINISH: begin
                // ending status and completion pulse in the same edge
                next_cur.phase = stream_write_pkg::ST_IDLE;
                next_cur.done = 1'b1;
                next_cur.status.busy = 1'b0;
                if (cur.feat.continuous_write) begin
                    // stream error, never error, when continuous
                    next_cur.status.stream_error = cur.had_err | cur.timed_out;
                    next_cur.status.error = 1'b0;
                end else begin
                    next_cur.status.stream_error = 1'b0;
                    next_cur.status.error = cur.had_err | cur.timed_out;
                end
            end
            default: begin
                next_cur.phase = stream_write_pkg::ST_IDLE;
            end
        endcase
    end

    // *****************************************
    // registers
    // *****************************************
    // stored defaults are cleared by reset: streams count as unconfigured
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            cur <= '0;
            cur.phase <= stream_write_pkg::ST_IDLE;
            cur.status.ready <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // *****************************************
    // outputs
    // *****************************************
    // urgency is passed on as a level; the data path gives it priority
    assign o_xfer_req = (cur.phase == stream_write_pkg::ST_XFER);
    assign o_flush_req = (cur.phase == stream_write_pkg::ST_FLUSH);
    assign o_feature = cur.feat;
    assign o_stream_default = cur.def_limit[cur.feat.stream_selector];
    assign o_sectors_left = cur.left;
    assign o_status = cur.status;
    assign o_err_log = cur.elog;
    assign o_done = cur.done;
endmodule // stream_write_feature_decode
`default_nettype wire

// file: hdl/stream_write_pkg.sv
// constants and carriers for the stream write feature decoder
// assumes one 250 MHz core clock and command block writes seen as a strobe
// Function
// - urgent bit asks fastest completion within limit
// - continuous-write never aborts on transfer errors
// - continuous errors: full transfer, stream-error, log type
// - continuous timeout stops, stream-error, timeout flag set
// - always try moving all sectors within limit; non-continuous write stops at its first transfer error
// - flush bit commits stream data before completion
// - resume bit restarts stream recovery at error address; here it is only decoded onto o_feature, no recovery logic
// - low three feature bits select stream parameters
// - limit equals previous byte times identify unit
// - zero previous byte uses stored stream default
// - limit runs from command write to completion
// - zero sector count means 65536 sectors
// - error bit zero flags completion timeout
package stream_write_pkg;
    // *****************************************
    // command and field positions
    // *****************************************
    localparam logic [7:0] OPC_WRITE_STREAM_DMA = 8'h3a; // command code
    localparam int URGENT_BIT = 7;
    localparam int CONTINUOUS_BIT = 6;
    localparam int FLUSH_BIT = 5;
    localparam int RESUME_BIT = 4;
    localparam int SELECTOR_LSB = 0;
    localparam int SELECTOR_W = 3;
    localparam int STREAMS = 8;
    // *****************************************
    // timing
    // *****************************************
    localparam int CLK_PERIOD_PS = 4000; // 250 MHz core clock
    localparam int MICROSECOND_PS = 1000000;
    localparam int CYCLES_PER_US = MICROSECOND_PS / CLK_PERIOD_PS;
    localparam logic [31:0] MIN_LIMIT_US = 32'h0000_03e8; // device minimum limit
    localparam logic [16:0] FULL_COUNT = 17'h1_0000; // zero count means this many
    // command block as written by the host
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] feature_current_byte;
        logic [7:0] feature_previous_byte;
        logic [7:0] sector_count_low_byte;
        logic [7:0] sector_count_high_byte;
    } cmd_block_t;
    // decoded feature bits
    typedef struct packed {
        logic urgent_request;
        logic continuous_write;
        logic flush;
        logic resume_after_error;
        logic [2:0] stream_selector;
    } feature_t;
    // transfer error kinds reported by the data path
    typedef struct packed {
        logic interface_crc_error;
        logic id_not_found_error;
        logic aborted_command_error;
    } xfer_err_t;
    // ending status bits
    typedef struct packed {
        logic busy;
        logic ready;
        logic stream_error;
        logic error;
    } status_t;
    // error log, error register bit 0 is the timeout flag
    typedef struct packed {
        logic interface_crc_error;
        logic id_not_found_error;
        logic aborted_command_error;
        logic completion_timeout_flag;
    } err_log_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_FLUSH = 2'b11,
        ST_FINISH = 2'b10
    } phase_t;
endpackage

// file: tb/stream_write_host_model.sv
// host controller model: writes the command block registers
// assumes caller enters issue just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module stream_write_host_model (
    input wire logic i_core_clk,
    output logic o_cmd_wr,
    output stream_write_pkg::cmd_block_t o_cmd
);
    // idle bus at time zero
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd = '0;
    end
    // one command register write, held until the sampling edge
    task automatic issue(input logic [7:0] opc, input logic [7:0] feat,
                         input logic [7:0] prev, input logic [15:0] cnt);
        o_cmd_wr = 1'b1;
        o_cmd = {opc, feat, prev, cnt[7:0], cnt[15:8]};
        @(posedge i_core_clk);
        #1;
        o_cmd_wr = 1'b0;
        o_cmd = ~o_cmd; // released block must not keep its old value
    endtask
endmodule // stream_write_host_model
`default_nettype wire

// file: tb/stream_write_feature_decode_assertions.sv
// port checker for the stream write decoder
// assumes one clock domain, bound onto every decoder instance
`timescale 1ns/1ps
`default_nettype none
module stream_write_checker #(
    parameter int MIN_LIMIT = 32'h0000_03e8 // minimum limit, unused here
) (
    input wire logic i_core_clk, input wire logic i_nrst, input wire logic i_cmd_wr,
    input wire stream_write_pkg::cmd_block_t i_cmd, input wire logic [31:0] i_limit_unit,
    input wire logic i_cfg_wr, input wire logic [2:0] i_cfg_stream,
    input wire logic [31:0] i_cfg_limit, input wire logic i_sector_done,
    input wire logic i_xfer_err, input wire stream_write_pkg::xfer_err_t i_xfer_err_kind,
    input wire logic i_flush_done, input wire logic o_xfer_req, input wire logic o_flush_req,
    input wire stream_write_pkg::feature_t o_feature, input wire logic [31:0] o_stream_default,
    input wire logic [16:0] o_sectors_left, input wire stream_write_pkg::status_t o_status,
    input wire stream_write_pkg::err_log_t o_err_log, input wire logic o_done
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    logic take; // command accepted at this edge
    logic [16:0] req_cnt; // requested sectors, zero means the full count
    assign take = i_cmd_wr && !o_status.busy
        && i_cmd.opcode == stream_write_pkg::OPC_WRITE_STREAM_DMA;
    assign req_cnt = ({i_cmd.sector_count_high_byte, i_cmd.sector_count_low_byte} == 16'h0)
        ? stream_write_pkg::FULL_COUNT
        : {1'b0, i_cmd.sector_count_high_byte, i_cmd.sector_count_low_byte};
    property p_accept; take |=> o_status.busy && o_xfer_req; endproperty
    a_accept: assert property (p_accept) else $error("command not started");
    property p_decode;
        take |=> o_feature == {$past(i_cmd.feature_current_byte[7:4]),
                               $past(i_cmd.feature_current_byte[2:0])};
    endproperty
    a_decode: assert property (p_decode) else $error("feature decode wrong");
    property p_count; take |=> o_sectors_left == $past(req_cnt); endproperty
    a_count: assert property (p_count) else $error("sector count wrong");
    property p_dec;
        o_xfer_req && i_sector_done && !i_xfer_err && o_sectors_left > 17'h1
            |=> o_sectors_left == $past(o_sectors_left) - 17'h1;
    endproperty
    a_dec: assert property (p_dec) else $error("sector not counted");
    property p_nostop;
        o_feature.continuous_write && o_xfer_req && i_xfer_err && o_sectors_left > 17'h1
            |=> o_xfer_req;
    endproperty
    a_nostop: assert property (p_nostop) else $error("continuous write aborted");
    property p_flush;
        o_feature.flush && o_xfer_req && i_sector_done && o_sectors_left == 17'h1 |=> o_flush_req;
    endproperty
    a_flush: assert property (p_flush) else $error("flush not started");
    property p_hold; o_flush_req && !i_flush_done |=> !o_done; endproperty
    a_hold: assert property (p_hold) else $error("done before flush");
    property p_wcstat;
        o_done && o_feature.continuous_write
            |-> !o_status.error && o_status.stream_error == (|o_err_log);
    endproperty
    a_wcstat: assert property (p_wcstat) else $error("continuous status wrong");
    property p_pulse; o_done |-> !o_status.busy ##1 !o_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done pulse wrong");
    c_cont: cover property (take && i_cmd.feature_current_byte[6]);
    c_tout: cover property (o_done && o_err_log.completion_timeout_flag);
    c_flush: cover property (o_flush_req && i_flush_done);
endmodule // stream_write_checker
bind stream_write_feature_decode stream_write_checker #(.MIN_LIMIT(MIN_LIMIT)) u_chk (
    .i_core_clk, .i_nrst, .i_cmd_wr, .i_cmd, .i_limit_unit, .i_cfg_wr, .i_cfg_stream,
    .i_cfg_limit, .i_sector_done, .i_xfer_err, .i_xfer_err_kind, .i_flush_done,
    .o_xfer_req, .o_flush_req, .o_feature, .o_stream_default, .o_sectors_left,
    .o_status, .o_err_log, .o_done);
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the stream write decoder
// assumes minimum limit 2 us so timeouts stay short
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic cmd_wr;
    stream_write_pkg::cmd_block_t cmd;
    logic i_cfg_wr = 1'b0;
    logic [31:0] i_limit_unit = 32'h1;
    logic sd = 1'b0, xe = 1'b0, fd = 1'b0;
    stream_write_pkg::xfer_err_t kind = '0;
    logic xreq, freq, done;
    stream_write_pkg::feature_t feat;
    logic [31:0] dflt;
    logic [16:0] left;
    stream_write_pkg::status_t st;
    stream_write_pkg::err_log_t log;
    int error_cnt = 0, cmp_count = 0, cycles = 0, n;
    always #2 i_core_clk = ~i_core_clk;
    stream_write_host_model host (.i_core_clk(i_core_clk), .o_cmd_wr(cmd_wr), .o_cmd(cmd));
    stream_write_feature_decode #(.MIN_LIMIT(2)) dut (.i_core_clk(i_core_clk),
        .i_nrst(i_nrst), .i_cmd_wr(cmd_wr), .i_cmd(cmd), .i_limit_unit(i_limit_unit),
        .i_cfg_wr(i_cfg_wr), .i_cfg_stream(3'h3), .i_cfg_limit(32'h3), .i_sector_done(sd),
        .i_xfer_err(xe), .i_xfer_err_kind(kind), .i_flush_done(fd), .o_xfer_req(xreq),
        .o_flush_req(freq), .o_feature(feat), .o_stream_default(dflt), .o_sectors_left(left),
        .o_status(st), .o_err_log(log), .o_done(done));
    task automatic conclude;
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one cycle of data path events, then one quiet cycle
    task automatic step(input logic s, input logic e, input logic [2:0] k, input logic f);
        {sd, xe, kind, fd} = {s, e, k, f};
        @(posedge i_core_clk); #1;
        {sd, xe, kind, fd} = '0;
        @(posedge i_core_clk); #1;
    endtask
    // bounded wait for the completion pulse, counting cycles
    task automatic wait_done;
        n = 0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge i_core_clk); #1;
            n++;
        end
        chk("done", 32'h1, done);
    endtask
    // timed-out command; limit given in microseconds
    task automatic timed(input logic [7:0] f, input logic [7:0] prev, input int us);
        host.issue(stream_write_pkg::OPC_WRITE_STREAM_DMA, f, prev, 16'h0000);
        wait_done;
        chk("cycles", 32'h1, 32'(n > us * 250 - 10 && n < us * 250 + 10));
        chk("log", 32'h1, log);
    endtask
    // cut a hang short
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    // ******************************************
    // scenarios
    // ******************************************
    initial begin
        repeat (10) @(posedge i_core_clk);
        #1;
        i_nrst = 1'b1;
        chk("ready", 32'h1, st.ready);
        host.issue(8'h3b, 8'h40, 8'h00, 16'h0001);
        @(posedge i_core_clk); #1;
        chk("refused", 32'h0, st.busy);
        host.issue(stream_write_pkg::OPC_WRITE_STREAM_DMA, 8'hd5, 8'h00, 16'h0003);
        chk("feature", 32'h6d, feat);
        chk("left", 32'h3, left);
        step(0, 1, 3'b100, 0);
        repeat (3) step(1, 0, 3'b000, 0);
        wait_done;
        chk("cont status", 32'h6, st);
        chk("cont log", 32'h8, log);
        host.issue(stream_write_pkg::OPC_WRITE_STREAM_DMA, 8'h22, 8'h04, 16'h0001);
        step(1, 0, 3'b000, 0);
        chk("flush req", 32'h1, freq);
        chk("early done", 32'h0, done);
        step(0, 0, 3'b000, 1);
        wait_done;
        chk("flush status", 32'h4, st);
        host.issue(stream_write_pkg::OPC_WRITE_STREAM_DMA, 8'h00, 8'h00, 16'h0005);
        step(0, 1, 3'b010, 0);
        wait_done;
        chk("abort status", 32'h5, st);
        chk("abort log", 32'h4, log);
        i_cfg_wr = 1'b1;
        @(posedge i_core_clk); #1;
        i_cfg_wr = 1'b0;
        timed(8'h43, 8'h00, 3);
        chk("wc timeout", 32'h6, st);
        chk("default", 32'h3, dflt);
        timed(8'h00, 8'h01, 2);
        i_limit_unit = 32'h2;
        timed(8'h00, 8'h02, 4);
        chk("err timeout", 32'h5, st);
        conclude();
    end
endmodule // tb
`default_nettype wire
